//--- mem_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_device_model #(parameter int INIT_NOPS = 1024)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire mem_init_pkg::mem_cmd_t memCmd,
   output logic ready
);
   logic [7:0] bankSeen;
   logic loaded;
   int nops;
   // Idle cycles before the first load are settling time and must not count.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bankSeen <= 8'h0;
         loaded <= 1'b0;
         nops <= 0;
      end
      else
      begin
         if (memCmd.cmd == mem_init_pkg::CMD_MODE_LOAD)
            loaded <= 1'b1;
         if (loaded && memCmd.cmd == mem_init_pkg::CMD_NOP)
            nops <= nops + 1;
         if (memCmd.cmd == mem_init_pkg::CMD_BANK_REFRESH)
            bankSeen[memCmd.bank] <= 1'b1;
      end
   end
   assign ready = &bankSeen && nops >= INIT_NOPS;
endmodule : mem_device_model
`default_nettype wire

//--- mem_init_pkg.sv
package mem_init_pkg;
   typedef enum logic [2:0]
   {
      CMD_NOP = 3'h0,
      CMD_MODE_LOAD = 3'h1,
      CMD_BANK_REFRESH = 3'h2
   } cmd_t;
   typedef enum logic [2:0]
   {
      ST_SETTLE = 3'h0,
      ST_DUMMY = 3'h1,
      ST_VALID = 3'h3,
      ST_GAP = 3'h2,
      ST_INIT_REF = 3'h6,
      ST_ROW_WAIT = 3'h7,
      ST_RUN = 3'h5
   } state_t;
   typedef struct packed
   {
      cmd_t cmd;
      logic [2:0] bank;
      logic [17:0] addr;
   } mem_cmd_t;
endpackage : mem_init_pkg

//--- mem_init_refresh_sequence.sv
// Operation
// - Only no-operation commands are driven from power-up until the mode loads begin.
// - Stable no-operation conditions are held for at least 200 us before the first mode load.
// - At least three mode loads are issued in a row, two or more dummies then one valid load.
// - The dummy and valid mode loads occupy consecutive cycles with no recovery gap between them.
// - All address lines are driven low during the dummy mode loads.
// - After the mode load gap, one refresh per bank and 1,024 no-operations precede normal operation.
// - The eight initialization refreshes may sit anywhere among the 1,024 no-operations.
// - A bank is not given a valid command until the row cycle time after its refresh has passed; the code waits only after the initialization refreshes.
// - In normal operation the average refresh interval stays at or below 0.24 us.
// - Optionally, eight refreshes on consecutive cycles are repeated every 1.95 us.
// - A mode load is issued only while all banks are idle and no burst is in progress.
// - After a mode load, at least 6 cycles pass before any other command.
`timescale 1ns/1ps
`default_nettype none
`include "mem_init_regs.svh"
module mem_init_refresh_sequence #(
   parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
   parameter int DUMMY_LOADS = `DUMMY_LOADS,
   parameter int INIT_NOPS = `INIT_NOP_COUNT
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic startReq,
   input wire logic burstRefresh,
   input wire logic [17:0] modeValue,
   output var mem_init_pkg::mem_cmd_t memCmd,
   output logic initDone,
   output logic refreshSlot
);
   typedef struct packed
   {
      mem_init_pkg::state_t state;
      logic [31:0] count;
      logic [10:0] nops;
      logic [3:0] refs;
      logic [3:0] loads;
      logic [15:0] refTimer;
      logic [3:0] burstLeft;
      logic [2:0] nextBank;
      mem_init_pkg::mem_cmd_t cmd;
      logic done;
      logic slot;
   } seq_t;

   seq_t s_reg;
   seq_t s_next;

   always_comb
   begin
      s_next = s_reg;
      s_next.cmd = '{cmd: mem_init_pkg::CMD_NOP, bank: 3'h0, addr: 18'h0};
      s_next.slot = 1'b0;
      unique case (s_reg.state)
         mem_init_pkg::ST_SETTLE:
         begin
            // The wait only counts once the caller reports supplies and clocks stable.
            if (startReq)
            begin
               if (s_reg.count >= 32'(SETTLE_CYCLES - 1))
               begin
                  s_next.state = mem_init_pkg::ST_DUMMY;
                  s_next.count = 32'h0;
               end
               else
               begin
                  s_next.count = s_reg.count + 32'h1;
               end
            end
            else
            begin
               s_next.count = 32'h0;
            end
         end
         mem_init_pkg::ST_DUMMY:
         begin
            // Nothing else is open at this point, so banks are idle.
            s_next.cmd.cmd = mem_init_pkg::CMD_MODE_LOAD;
            s_next.cmd.addr = 18'h0;
            s_next.loads = s_reg.loads + 4'h1;
            if (s_reg.loads >= 4'(DUMMY_LOADS - 1))
            begin
               s_next.state = mem_init_pkg::ST_VALID;
            end
         end
         mem_init_pkg::ST_VALID:
         begin
            s_next.cmd.cmd = mem_init_pkg::CMD_MODE_LOAD;
            s_next.cmd.addr = {8'h00, modeValue[9:0]};
            s_next.loads = s_reg.loads + 4'h1;
            s_next.state = mem_init_pkg::ST_GAP;
            s_next.count = 32'h0;
         end
         mem_init_pkg::ST_GAP:
         begin
            // The valid load leaves the pins in this cycle, so it starts the gap count.
            if (s_reg.count >= 32'(`MODE_LOAD_GAP - 1))
            begin
               s_next.state = mem_init_pkg::ST_INIT_REF;
               s_next.count = 32'h0;
            end
            else
            begin
               s_next.count = s_reg.count + 32'h1;
            end
         end
         mem_init_pkg::ST_INIT_REF:
         begin
            // Refreshes lead, then the idle run; any placement would do.
            if (s_reg.refs < 4'(`BANK_COUNT))
            begin
               s_next.cmd.cmd = mem_init_pkg::CMD_BANK_REFRESH;
               s_next.cmd.bank = s_reg.refs[2:0];
               s_next.refs = s_reg.refs + 4'h1;
            end
            else if (s_reg.nops < 11'(INIT_NOPS))
            begin
               s_next.nops = s_reg.nops + 11'h1;
            end
            else
            begin
               s_next.state = mem_init_pkg::ST_ROW_WAIT;
               s_next.count = 32'h0;
            end
         end
         mem_init_pkg::ST_ROW_WAIT:
         begin
            // With 1,024 idles after the last refresh this is already met, but it is kept explicit.
            if (s_reg.count >= 32'(`ROW_CYCLE_GAP - 1))
            begin
               s_next.state = mem_init_pkg::ST_RUN;
               s_next.done = 1'b1;
               s_next.refTimer = 16'h0;
            end
            else
            begin
               s_next.count = s_reg.count + 32'h1;
            end
         end
         mem_init_pkg::ST_RUN:
         begin
            s_next.refTimer = s_reg.refTimer + 16'h1;
            if (s_reg.burstLeft != 4'h0)
            begin
               s_next.cmd.cmd = mem_init_pkg::CMD_BANK_REFRESH;
               s_next.cmd.bank = s_reg.nextBank;
               s_next.nextBank = s_reg.nextBank + 3'h1;
               s_next.burstLeft = s_reg.burstLeft - 4'h1;
            end
            // The timer also runs through the burst cycles, so the burst period is the full interval.
            else if (burstRefresh && s_reg.refTimer >= 16'(`REFRESH_BURST_CYCLES - 1))
            begin
               s_next.refTimer = 16'h0;
               s_next.burstLeft = 4'(`BANK_COUNT);
            end
            else if (!burstRefresh && s_reg.refTimer >= 16'(`REFRESH_AVG_CYCLES - 1))
            begin
               s_next.refTimer = 16'h0;
               s_next.cmd.cmd = mem_init_pkg::CMD_BANK_REFRESH;
               s_next.cmd.bank = s_reg.nextBank;
               s_next.nextBank = s_reg.nextBank + 3'h1;
            end
            else
            begin
               // Free cycle: the user may put a read or write here.
               s_next.slot = 1'b1;
            end
         end
         default:
         begin
            s_next.state = mem_init_pkg::ST_SETTLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg <= '{state: mem_init_pkg::ST_SETTLE, cmd: '{cmd: mem_init_pkg::CMD_NOP, bank: 3'h0, addr: 18'h0},
                    default: '0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign memCmd = s_reg.cmd;
   assign initDone = s_reg.done;
   assign refreshSlot = s_reg.slot;
endmodule : mem_init_refresh_sequence
`default_nettype wire

//--- mem_init_refresh_sequence_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mem_init_refresh_sequence_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic startReq,
   input wire logic burstRefresh,
   input wire mem_init_pkg::mem_cmd_t memCmd,
   input wire logic initDone,
   input wire logic refreshSlot
);
   wire logic isLoad = memCmd.cmd == mem_init_pkg::CMD_MODE_LOAD;
   wire logic isRef = memCmd.cmd == mem_init_pkg::CMD_BANK_REFRESH;
   wire logic isNop = memCmd.cmd == mem_init_pkg::CMD_NOP;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   AST_LOAD_RUN: assert property ($rose(isLoad) |-> isLoad [*3]) else $error("short load run");
   AST_DUMMY_LOW: assert property (isLoad ##1 isLoad |-> $past(memCmd.addr) == 18'h0) else $error("dummy addr");
   AST_LOAD_GAP: assert property ($fell(isLoad) |-> isNop [*6]) else $error("load gap");
   AST_SETTLE: assert property (!startReq && isNop && !initDone |=> !isLoad) else $error("early load");
   AST_DONE_HOLD: assert property (initDone |=> initDone) else $error("done dropped");
   AST_BANK_STEP: assert property (isRef && $past(isRef) |-> memCmd.bank == $past(memCmd.bank) + 3'h1)
      else $error("bank order");
   // A switch to bursts stretches the wait legitimately, so the burst select aborts this check.
   AST_REF_AVG: assert property (@(posedge clk) disable iff (!rst_n || burstRefresh)
      initDone && isRef |-> ##[1:30] isRef) else $error("refresh late");
   AST_SLOT_RUN: assert property (refreshSlot |-> initDone && !isLoad) else $error("slot early");
   cover property ($rose(initDone));
   cover property (isRef [*8]);
   cover property ($fell(isLoad));
endmodule : mem_init_refresh_sequence_properties
bind mem_init_refresh_sequence mem_init_refresh_sequence_properties chk (.clk(clk), .rst_n(rst_n),
   .startReq(startReq), .burstRefresh(burstRefresh), .memCmd(memCmd), .initDone(initDone),
   .refreshSlot(refreshSlot));
`default_nettype wire

//--- mem_init_refresh_sequence_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mem_init_refresh_sequence_tb_top;
   localparam int SETTLE = 20;
   localparam int NOPS = 16;
   localparam logic [17:0] LD = 18'(mem_init_pkg::CMD_MODE_LOAD);
   localparam logic [17:0] RF = 18'(mem_init_pkg::CMD_BANK_REFRESH);
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic startReq = 1'b0;
   logic burstRefresh = 1'b0;
   logic [17:0] modeValue = 18'h2c0a5;
   mem_init_pkg::mem_cmd_t memCmd;
   logic initDone;
   logic ready;
   logic refreshSlot;
   int err_total = 0;
   int samples_checked = 0;
   int n;
   wire logic [17:0] cmd = 18'(memCmd.cmd);
   always #4 clk = ~clk;
   mem_init_refresh_sequence #(.SETTLE_CYCLES(SETTLE), .DUMMY_LOADS(2), .INIT_NOPS(NOPS)) DUT (.clk(clk),
      .rst_n(rst_n), .startReq(startReq), .burstRefresh(burstRefresh), .modeValue(modeValue),
      .memCmd(memCmd), .initDone(initDone), .refreshSlot(refreshSlot));
   mem_device_model #(.INIT_NOPS(NOPS)) partner (.clk(clk), .rst_n(rst_n), .memCmd(memCmd), .ready(ready));
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   // The bound keeps a missing command from hanging the run.
   task automatic await(input logic [17:0] c);
      n = 0;
      step;
      while (cmd !== c && n < 400)
      begin
         n++;
         step;
      end
   endtask : await
   task automatic settle_restart;
      startReq <= 1'b1;
      repeat (10) @(posedge clk);
      startReq <= 1'b0;
      @(posedge clk);
      startReq <= 1'b1;
      await(LD);
      chk(18'(n >= SETTLE - 1), 18'h1);
   endtask : settle_restart
   task automatic init_walk;
      for (int i = 0; i < 3; i++)
      begin
         chk(cmd, LD);
         chk(memCmd.addr, i < 2 ? 18'h0 : 18'h000a5);
         step;
      end
      await(RF);
      chk(18'(n), 18'h5);
      for (int b = 0; b < 8; b++)
      begin
         chk({memCmd.bank, cmd[14:0]}, {3'(b), RF[14:0]});
         step;
      end
      repeat (NOPS + 8)
      begin
         chk({initDone, cmd[16:0]}, 18'h0);
         step;
      end
      repeat (2) step;
      chk(18'(initDone & ready), 18'h1);
   endtask : init_walk
   task automatic single_gap;
      repeat (4)
      begin
         await(RF);
         chk(18'(n < 30), 18'h1);
         chk(18'(refreshSlot), 18'h0);
         step;
         chk(18'(refreshSlot), 18'h1);
      end
   endtask : single_gap
   task automatic burst_period;
      @(posedge clk);
      burstRefresh <= 1'b1;
      repeat (2) step;
      // Measure from the end of a whole burst, so the gap is not taken mid-interval.
      await(RF);
      while (cmd === RF) step;
      await(RF);
      chk(18'(n + 1), 18'heb);
      repeat (8)
      begin
         chk(cmd, RF);
         step;
      end
   endtask : burst_period
   task automatic test_done;
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      settle_restart;
      init_walk;
      single_gap;
      burst_period;
      test_done;
   end
   initial
   begin
      #100000;
      err_total++;
      test_done;
   end
endmodule : mem_init_refresh_sequence_tb_top
`default_nettype wire

//--- mem_init_regs.svh
`ifndef MEM_INIT_REGS_SVH
`define MEM_INIT_REGS_SVH
// Clock period in picoseconds (125 MHz).
`define CLK_PERIOD_PS 8000
// Settling time before the first mode load, in microseconds.
`define SETTLE_TIME_US 200
`define SETTLE_CYCLES ((`SETTLE_TIME_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Dummy mode loads issued ahead of the valid one.
`define DUMMY_LOADS 2
// Gap after a mode load, in memory clock cycles.
`define MODE_LOAD_GAP 6
// Bank count and idle commands of the refresh phase.
`define BANK_COUNT 8
`define INIT_NOP_COUNT 1024
// Longest average refresh interval, in nanoseconds.
`define REFRESH_AVG_NS 240
`define REFRESH_AVG_CYCLES ((`REFRESH_AVG_NS * 1000) / `CLK_PERIOD_PS)
// Interval of an eight-refresh burst, in nanoseconds.
`define REFRESH_BURST_NS 1950
`define REFRESH_BURST_CYCLES ((`REFRESH_BURST_NS * 1000) / `CLK_PERIOD_PS)
// Row cycle time, in clock cycles.
`define ROW_CYCLE_GAP 8
`endif
